// ### hdl/antenna_seg_pkg.sv
package antenna_seg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_DEPTH_CTRL = 8'h24;
    localparam logic [7:0] ADDR_DEPTH_RESULT = 8'h25;
    localparam logic [7:0] ADDR_MOD_DISABLE = 8'h26;
    localparam logic [7:0] ADDR_NORM_DISABLE = 8'h27;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h31;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h32;
    localparam logic [7:0] ADDR_COMMAND = 8'h33;
    localparam logic [7:0] ADDR_BLOCK_STATE = 8'h34;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SRC_SEL_BIT = 7;
    localparam int DEPTH_MSB = 6;
    localparam int DEPTH_LSB = 1;
    localparam int CMD_RESTORE_BIT = 0;
    localparam int CMD_CALIBRATE_BIT = 1;
    localparam int IRQ_CAL_DONE_BIT = 0;
    localparam int IRQ_CAL_ERROR_BIT = 1;
    localparam int IRQ_COUNT = 2;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_TRISTATE_BIT = 1;
    localparam int STATE_MODULATING_BIT = 2;
    localparam int STATE_LAST_ERROR_BIT = 3;

    // ****************************************************************
    // Reset and special values
    // ****************************************************************
    localparam logic [7:0] RST_DEPTH_CTRL = 8'h00;
    localparam logic [7:0] RST_DEPTH_RESULT = 8'h00;
    localparam logic [7:0] RST_MOD_DISABLE = 8'h00;
    localparam logic [7:0] RST_NORM_DISABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] ALL_SEGMENTS_OFF = 8'hff;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_DECIDE, CAL_FINISH} cal_state_t;

endpackage : antenna_seg_pkg

// ### hdl/sticky_irq.sv
`timescale 1ns/10ps
module sticky_irq #(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Events and software access
    input wire logic [N-1:0] i_event,
    input wire logic i_enable_wr,
    input wire logic [N-1:0] i_enable_data,
    input wire logic [N-1:0] i_clear,
    // State
    output logic [N-1:0] o_status,
    output logic [N-1:0] o_enable,
    output logic o_irq
);

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_status <= '0;
        end else begin
            o_status <= (o_status & ~i_clear) | i_event;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_enable <= '0;
        end else if (i_enable_wr) begin
            o_enable <= i_enable_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(o_status & o_enable);
        end
    end

endmodule : sticky_irq

// ### hdl/depth_calibrator.sv
`timescale 1ns/10ps
module depth_calibrator #(
    parameter int WIDTH = 8,
    parameter int SETTLE = antenna_seg_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_too_deep,
    // Result
    output logic o_busy,
    output logic [WIDTH-1:0] o_trial,
    output logic o_done,
    output logic o_error
);

    antenna_seg_pkg::cal_state_t state;
    logic [WIDTH-1:0] bit_mask;
    logic [15:0] settle_cnt;
    logic [WIDTH-1:0] kept;

    // More disabled segments give deeper modulation; drop the bit if overshot
    assign kept = i_too_deep ? (o_trial & ~bit_mask) : o_trial;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= antenna_seg_pkg::CAL_IDLE;
            bit_mask <= '0;
            settle_cnt <= '0;
            o_trial <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_error <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_error <= 1'b0;
            if (i_abort) begin
                state <= antenna_seg_pkg::CAL_IDLE;
                o_busy <= 1'b0;
                o_trial <= '0;
            end else begin
                case (state)
                    antenna_seg_pkg::CAL_IDLE: begin
                        if (i_start) begin
                            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
                            o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
                            settle_cnt <= 16'(SETTLE - 1);
                            o_busy <= 1'b1;
                            state <= antenna_seg_pkg::CAL_SETTLE;
                        end
                    end
                    antenna_seg_pkg::CAL_SETTLE: begin
                        settle_cnt <= settle_cnt - 16'h0001;
                        if (settle_cnt == 16'h0000) begin
                            state <= antenna_seg_pkg::CAL_DECIDE;
                        end
                    end
                    antenna_seg_pkg::CAL_DECIDE: begin
                        if (bit_mask[0]) begin
                            o_trial <= kept;
                            state <= antenna_seg_pkg::CAL_FINISH;
                        end else begin
                            o_trial <= kept | (bit_mask >> 1);
                            bit_mask <= bit_mask >> 1;
                            settle_cnt <= 16'(SETTLE - 1);
                            state <= antenna_seg_pkg::CAL_SETTLE;
                        end
                    end
                    antenna_seg_pkg::CAL_FINISH: begin
                        // Target out of reach when every segment had to go
                        o_error <= &o_trial;
                        o_done <= 1'b1;
                        o_busy <= 1'b0;
                        state <= antenna_seg_pkg::CAL_IDLE;
                    end
                    default: begin
                        state <= antenna_seg_pkg::CAL_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : depth_calibrator

// ### hdl/antenna_driver_segment_ctrl.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// What this block does
// [RULE1] With source select 0 the modulated level follows the six-bit depth code in bits 6..1.
// [RULE2] A depth calibrate command run with source select 0 adjusts that level automatically.
// [RULE3] With source select 1 the modulated pattern comes from the manual segment register.
// [RULE4] The calibration outcome is shown in a read-only eight-bit result register, bit 7 MSB.
// [RULE5] A result bit of 1 disables its segment during the modulated state.
// [RULE6] A failed calibration loads all ones into the result register.
// [RULE7] With source select 1 a manual bit of 1 disables its segment while modulating.
// [RULE8] A normal-level bit of 1 disables its segment during unmodulated operation.
// [RULE9] Bits 7 down to 0 map to the 2, 4, 8, 16, 32, 64, 128 and 256 Ohm segments.
// [RULE10] All ones in the normal-level register puts the drivers in tristate; the code does so only while not modulating and no calibration runs.
// [RULE11] The depth control, manual and normal-level registers return to defaults at reset and on restore-defaults; the interrupt enable only at reset.
// [RULE12] The result register reads zero after reset and restore until a calibration ends.
// [RULE13] Each segment enable is the inverse of the disable bit of the selected pattern.
module antenna_driver_segment_ctrl #(
    parameter int SEGMENTS = 8,
    parameter int SETTLE = antenna_seg_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Transmitter state and analog feedback
    input wire logic i_am_modulate,
    input wire logic i_depth_too_deep,
    // Driver control
    output logic [SEGMENTS-1:0] o_segment_en,
    output logic o_driver_tristate,
    output logic [5:0] o_depth_target,
    output logic o_cal_busy,
    // Interrupt
    output logic o_irq
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] depth_control;
    logic [7:0] depth_result;
    logic [SEGMENTS-1:0] modulated_disable;
    logic [SEGMENTS-1:0] normal_disable;
    logic last_error;

    logic cmd_write;
    logic restore_defaults;
    logic cal_request;
    logic cal_start;
    logic source_manual;

    logic cal_done;
    logic cal_error;
    logic [SEGMENTS-1:0] cal_trial;

    localparam int IRQ_N = antenna_seg_pkg::IRQ_COUNT;
    logic [IRQ_N-1:0] irq_status;
    logic [IRQ_N-1:0] irq_enable;
    logic [IRQ_N-1:0] irq_event;
    logic [IRQ_N-1:0] irq_clear;

    logic [SEGMENTS-1:0] next_disable;
    logic next_tristate;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    assign cmd_write = hit(i_wr, i_addr, antenna_seg_pkg::ADDR_COMMAND);
    assign restore_defaults = cmd_write && i_wdata[antenna_seg_pkg::CMD_RESTORE_BIT];
    assign cal_request = cmd_write && i_wdata[antenna_seg_pkg::CMD_CALIBRATE_BIT];
    assign source_manual = depth_control[antenna_seg_pkg::SRC_SEL_BIT];
    // Calibration only runs off the depth code; restore takes priority
    assign cal_start = cal_request && !source_manual && !restore_defaults; // [RULE2]

    // ****************************************************************
    // Depth control register
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            depth_control <= antenna_seg_pkg::RST_DEPTH_CTRL; // [RULE11]
        end else if (restore_defaults) begin
            depth_control <= antenna_seg_pkg::RST_DEPTH_CTRL; // [RULE11]
        end else if (hit(i_wr, i_addr, antenna_seg_pkg::ADDR_DEPTH_CTRL)) begin
            // Bit 0 is unused and stays zero
            depth_control <= {i_wdata[7:1], 1'b0};
        end
    end

    // Depth code sets the analog target, bit 6 most significant
    assign o_depth_target = depth_control[antenna_seg_pkg::DEPTH_MSB:antenna_seg_pkg::DEPTH_LSB]; // [RULE1]

    // ****************************************************************
    // Manual modulated-level register
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            modulated_disable <= SEGMENTS'(antenna_seg_pkg::RST_MOD_DISABLE); // [RULE11]
        end else if (restore_defaults) begin
            modulated_disable <= SEGMENTS'(antenna_seg_pkg::RST_MOD_DISABLE); // [RULE11]
        end else if (hit(i_wr, i_addr, antenna_seg_pkg::ADDR_MOD_DISABLE)) begin
            modulated_disable <= i_wdata[SEGMENTS-1:0];
        end
    end

    // ****************************************************************
    // Normal-level register
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            normal_disable <= SEGMENTS'(antenna_seg_pkg::RST_NORM_DISABLE); // [RULE11]
        end else if (restore_defaults) begin
            normal_disable <= SEGMENTS'(antenna_seg_pkg::RST_NORM_DISABLE); // [RULE11]
        end else if (hit(i_wr, i_addr, antenna_seg_pkg::ADDR_NORM_DISABLE)) begin
            normal_disable <= i_wdata[SEGMENTS-1:0];
        end
    end

    // ****************************************************************
    // Calibration engine
    // ****************************************************************
    depth_calibrator #(
        .WIDTH(SEGMENTS),
        .SETTLE(SETTLE)
    ) i_depth_calibrator (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_start(cal_start),
        .i_abort(restore_defaults),
        .i_too_deep(i_depth_too_deep),
        .o_busy(o_cal_busy),
        .o_trial(cal_trial),
        .o_done(cal_done),
        .o_error(cal_error)
    );

    // ****************************************************************
    // Calibration result register
    // ****************************************************************
    // Bit 7 of the result drives the 2 Ohm segment, bit 0 the 256 Ohm one
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            depth_result <= antenna_seg_pkg::RST_DEPTH_RESULT; // [RULE12]
        end else if (restore_defaults) begin
            depth_result <= antenna_seg_pkg::RST_DEPTH_RESULT; // [RULE12]
        end else if (cal_done && cal_error) begin
            depth_result <= antenna_seg_pkg::ALL_SEGMENTS_OFF; // [RULE6]
        end else if (cal_done) begin
            depth_result <= 8'(cal_trial); // [RULE4]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_error <= 1'b0;
        end else if (restore_defaults) begin
            last_error <= 1'b0;
        end else if (cal_done) begin
            last_error <= cal_error;
        end
    end

    // ****************************************************************
    // Segment pattern selection
    // ****************************************************************
    // The trial pattern owns the drivers while a calibration runs
    always_comb begin
        if (o_cal_busy) begin
            next_disable = cal_trial; // [RULE2]
        end else if (i_am_modulate && source_manual) begin
            next_disable = modulated_disable; // [RULE3] [RULE7]
        end else if (i_am_modulate) begin
            next_disable = depth_result[SEGMENTS-1:0]; // [RULE1] [RULE5]
        end else begin
            next_disable = normal_disable; // [RULE8]
        end
    end

    // Tristate only when every normal segment is off and not modulating
    assign next_tristate = !i_am_modulate && !o_cal_busy
                           && (normal_disable == SEGMENTS'(antenna_seg_pkg::ALL_SEGMENTS_OFF));

    // ****************************************************************
    // Driver outputs
    // ****************************************************************
    // Per-segment enable, index i keeps its binary weight
    genvar seg;
    generate
        for (seg = 0; seg < SEGMENTS; seg++) begin : g_segment
            always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_segment_en[seg] <= 1'b1;
                end else begin
                    o_segment_en[seg] <= !next_disable[seg]; // [RULE13] [RULE9]
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_driver_tristate <= 1'b0;
        end else begin
            o_driver_tristate <= next_tristate; // [RULE10]
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_comb begin
        irq_event = '0;
        irq_event[antenna_seg_pkg::IRQ_CAL_DONE_BIT] = cal_done;
        irq_event[antenna_seg_pkg::IRQ_CAL_ERROR_BIT] = cal_done && cal_error;
    end

    assign irq_clear = hit(i_wr, i_addr, antenna_seg_pkg::ADDR_IRQ_CLEAR)
                       ? i_wdata[IRQ_N-1:0] : '0;

    sticky_irq #(
        .N(IRQ_N)
    ) i_sticky_irq (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_event(irq_event),
        .i_enable_wr(hit(i_wr, i_addr, antenna_seg_pkg::ADDR_IRQ_ENABLE)),
        .i_enable_data(i_wdata[IRQ_N-1:0]),
        .i_clear(irq_clear),
        .o_status(irq_status),
        .o_enable(irq_enable),
        .o_irq(o_irq)
    );

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data stands for one cycle only; unmapped and write-only read zero
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (!i_rd) begin
            o_rdata <= 8'h00;
        end else if (i_addr == antenna_seg_pkg::ADDR_DEPTH_CTRL) begin
            o_rdata <= depth_control;
        end else if (i_addr == antenna_seg_pkg::ADDR_DEPTH_RESULT) begin
            o_rdata <= depth_result; // [RULE4]
        end else if (i_addr == antenna_seg_pkg::ADDR_MOD_DISABLE) begin
            o_rdata <= 8'(modulated_disable);
        end else if (i_addr == antenna_seg_pkg::ADDR_NORM_DISABLE) begin
            o_rdata <= 8'(normal_disable);
        end else if (i_addr == antenna_seg_pkg::ADDR_IRQ_STATUS) begin
            o_rdata <= 8'(irq_status);
        end else if (i_addr == antenna_seg_pkg::ADDR_IRQ_ENABLE) begin
            o_rdata <= 8'(irq_enable);
        end else if (i_addr == antenna_seg_pkg::ADDR_BLOCK_STATE) begin
            o_rdata <= {4'h0, last_error, i_am_modulate, o_driver_tristate, o_cal_busy};
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule : antenna_driver_segment_ctrl

// ### verification/antenna_driver_segment_ctrl_chk.sv
`timescale 1ns/10ps
module antenna_driver_segment_ctrl_chk #(
    parameter int SEGMENTS = 8,
    parameter int SETTLE = 3
) (
    // Clock and reset
    input logic i_sys_clk,
    input logic i_arst_n,
    // Register port
    input logic [7:0] i_addr,
    input logic [7:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    input logic [7:0] o_rdata,
    // Drive state
    input logic i_am_modulate,
    input logic [SEGMENTS-1:0] o_segment_en,
    input logic o_driver_tristate,
    input logic [5:0] o_depth_target,
    input logic o_cal_busy,
    input logic o_irq
);
    // ****************
    // Register shadow
    // ****************
    localparam int CAL_MIN = 8 * SETTLE;
    localparam int CAL_MAX = 8 * (SETTLE + 2) + 2;
    logic cmd;
    logic restore;
    logic cal_cmd;
    logic aborted;
    logic [7:0] ctrl;
    logic [SEGMENTS-1:0] mod_shadow;
    logic [SEGMENTS-1:0] norm_shadow;
    logic [9:0] busy_len;
    assign cmd = i_wr && i_addr == 8'h33;
    assign restore = cmd && i_wdata[0];
    assign cal_cmd = cmd && i_wdata == 8'h02 && !o_cal_busy;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl <= 8'h00;
            mod_shadow <= '0;
            norm_shadow <= '0;
        end else if (restore) begin
            ctrl <= 8'h00;
            mod_shadow <= '0;
            norm_shadow <= '0;
        end else if (i_wr) begin
            if (i_addr == 8'h24) ctrl <= i_wdata;
            if (i_addr == 8'h26) mod_shadow <= i_wdata[SEGMENTS-1:0];
            if (i_addr == 8'h27) norm_shadow <= i_wdata[SEGMENTS-1:0];
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_len <= 10'h000;
            aborted <= 1'b0;
        end else begin
            busy_len <= o_cal_busy ? busy_len + 10'h001 : 10'h000;
            aborted <= o_cal_busy ? (aborted || restore) : 1'b0;
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    a_read_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_tristate_off: assert property (o_driver_tristate |-> o_segment_en == '0)
        else $error("tristate with segments on");
    a_tristate_mod: assert property (i_am_modulate |=> !o_driver_tristate)
        else $error("tristate while modulating");
    a_norm_pattern: assert property (
        (!i_am_modulate && !o_cal_busy && !i_wr) [*3]
        |-> o_segment_en == ~norm_shadow) else $error("normal pattern wrong");
    a_manual_pattern: assert property (
        (i_am_modulate && ctrl[7] && !o_cal_busy && !i_wr) [*3]
        |-> o_segment_en == ~mod_shadow) else $error("manual pattern wrong");
    a_depth_code: assert property (i_wr && i_addr == 8'h24 |=> o_depth_target == ctrl[6:1])
        else $error("depth code not driven");
    a_restore_clear: assert property (restore |-> ##[1:2] o_depth_target == 6'h00)
        else $error("restore left depth code");
    a_cal_refused: assert property (cal_cmd && ctrl[7] |=> !o_cal_busy [*3])
        else $error("calibration ran with manual source");
    a_cal_start: assert property (cal_cmd && !ctrl[7] |-> ##[1:2] o_cal_busy)
        else $error("calibration did not start");
    a_cal_length: assert property ($fell(o_cal_busy) && !aborted
        |-> busy_len >= CAL_MIN && busy_len <= CAL_MAX) else $error("calibration length wrong");
    a_irq_masked: assert property (i_wr && i_addr == 8'h31 && i_wdata[1:0] == 2'b00
        |-> ##2 !o_irq) else $error("interrupt while masked");
    c_cal_done: cover property ($fell(o_cal_busy));
    c_tristate: cover property (o_driver_tristate);
    c_irq: cover property (o_irq);
endmodule : antenna_driver_segment_ctrl_chk

bind antenna_driver_segment_ctrl antenna_driver_segment_ctrl_chk #(
    .SEGMENTS(SEGMENTS), .SETTLE(SETTLE)) i_antenna_driver_segment_ctrl_chk (.*);

// ### verification/antenna_driver_segment_ctrl_bench.sv
`timescale 1ns/10ps
module antenna_driver_segment_ctrl_bench;
    // ****************
    // Stimulus and design
    // ****************
    logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_am_modulate = 1'b0, i_depth_too_deep = 1'b0, cal_on = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
    logic [7:0] o_rdata, o_segment_en;
    logic [5:0] o_depth_target;
    logic o_driver_tristate, o_cal_busy, o_irq;
    int err_count = 0;
    int comparisons = 0;

    always #10 i_sys_clk = ~i_sys_clk;
    // Too deep once the trial pattern is above 0x5a, so the search ends there
    always @(posedge i_sys_clk) i_depth_too_deep <= cal_on && (~o_segment_en > 8'h5a);

    antenna_driver_segment_ctrl #(.SETTLE(3)) i_antenna_driver_segment_ctrl (.*);
    // ****************
    // Tasks and scenarios
    // ****************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check8(o_rdata, exp, what);
    endtask : reg_chk
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : wait_cycles
    task automatic set_mod(input logic v);
        @(posedge i_sys_clk);
        i_am_modulate <= v;
        wait_cycles(2);
    endtask : set_mod
    task automatic cal_run(input logic deep);
        int n = 0;
        cal_on = deep;
        reg_wr(8'h33, 8'h02);
        wait_cycles(2);
        check8(8'(o_cal_busy), 8'h01, "busy");
        while (o_cal_busy === 1'b1 && n < 200) begin
            @(posedge i_sys_clk);
            n++;
        end
        #1;
        cal_on = 1'b0;
        check8(8'(o_cal_busy), 8'h00, "busy end");
    endtask : cal_run
    task automatic chk_defaults;
        reg_chk(8'h24, 8'h00, "depth ctrl");
        reg_chk(8'h25, 8'h00, "result");
        reg_chk(8'h26, 8'h00, "manual");
        reg_chk(8'h27, 8'h00, "normal");
    endtask : chk_defaults
    task automatic t_reset;
        chk_defaults();
        check8(o_segment_en, 8'hff, "segments");
        check8(8'(o_driver_tristate), 8'h00, "tristate");
        $display("test reset done");
    endtask : t_reset
    task automatic t_normal;
        reg_wr(8'h27, 8'hc0);
        wait_cycles(2);
        check8(o_segment_en, 8'h3f, "2 and 4 Ohm off");
        reg_chk(8'h27, 8'hc0, "normal readback");
        reg_wr(8'h27, 8'hff);
        wait_cycles(2);
        check8(8'(o_driver_tristate), 8'h01, "tristate");
        check8(o_segment_en, 8'h00, "all off");
        reg_chk(8'h34, 8'h02, "state tristate");
        set_mod(1'b1);
        check8(8'(o_driver_tristate), 8'h00, "tristate modulating");
        check8(o_segment_en, 8'hff, "zero result");
        set_mod(1'b0);
        reg_wr(8'h27, 8'h01);
        wait_cycles(2);
        check8(o_segment_en, 8'hfe, "256 Ohm off");
        $display("test normal done");
    endtask : t_normal
    task automatic t_depth;
        reg_wr(8'h24, 8'h7f);
        wait_cycles(1);
        check8({2'b00, o_depth_target}, 8'h3f, "depth code");
        reg_chk(8'h24, 8'h7e, "depth readback");
        $display("test depth done");
    endtask : t_depth
    task automatic t_manual;
        reg_wr(8'h24, 8'h80);
        reg_wr(8'h26, 8'h81);
        set_mod(1'b1);
        check8(o_segment_en, 8'h7e, "manual pattern");
        reg_wr(8'h33, 8'h02);
        wait_cycles(3);
        check8(8'(o_cal_busy), 8'h00, "no calibration");
        set_mod(1'b0);
        check8(o_segment_en, 8'hfe, "back to normal");
        $display("test manual done");
    endtask : t_manual
    task automatic t_cal;
        reg_wr(8'h24, 8'h00);
        reg_wr(8'h31, 8'h03);
        cal_run(1'b1);
        reg_chk(8'h25, 8'h5a, "calibrated result");
        reg_chk(8'h30, 8'h01, "status done");
        check8(8'(o_irq), 8'h01, "irq raised");
        set_mod(1'b1);
        check8(o_segment_en, 8'ha5, "calibrated pattern");
        set_mod(1'b0);
        reg_wr(8'h32, 8'h01);
        wait_cycles(2);
        check8(8'(o_irq), 8'h00, "irq cleared");
        $display("test calibration done");
    endtask : t_cal
    task automatic t_cal_err;
        reg_wr(8'h31, 8'h00);
        cal_run(1'b0);
        reg_chk(8'h25, 8'hff, "failed result");
        check8(8'(o_irq), 8'h00, "irq masked");
        reg_wr(8'h31, 8'h02);
        wait_cycles(2);
        check8(8'(o_irq), 8'h01, "error irq");
        reg_chk(8'h34, 8'h08, "state error");
        $display("test calibration error done");
    endtask : t_cal_err
    task automatic t_restore;
        reg_wr(8'h24, 8'h55);
        reg_wr(8'h26, 8'h12);
        reg_wr(8'h33, 8'h02);
        reg_wr(8'h33, 8'h01);
        wait_cycles(2);
        check8(8'(o_cal_busy), 8'h00, "aborted");
        check8({2'b00, o_depth_target}, 8'h00, "depth code cleared");
        chk_defaults();
        reg_wr(8'h25, 8'h33);
        reg_chk(8'h25, 8'h00, "result read only");
        reg_wr(8'h40, 8'hff);
        reg_chk(8'h40, 8'h00, "unmapped");
        $display("test restore done");
    endtask : t_restore
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        t_reset();
        t_normal();
        t_depth();
        t_manual();
        t_cal();
        t_cal_err();
        t_restore();
        complete_run();
    end
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule : antenna_driver_segment_ctrl_bench
